/* quad_encoder_model.sv */
/*
  Far-side pin source: quadrature encoders and index pulses for four channels.
  Assumes callers step it from the testbench, on the block's clock.
*/
`timescale 1ns/10ps
module quad_encoder_model
(
  input  wire logic               clock,
  output servo_io_pkg::enc_pins_s pins
);
  logic [1:0] phase [servo_io_pkg::NUM_CH];

  initial
  begin
    pins = '0;
    foreach (phase[i]) phase[i] = 2'h0;
  end

  // One gray step, held four cycles; A leads B when counting up
  task automatic step(input int ch, input bit up);
    phase[ch] = up ? phase[ch] + 2'h1 : phase[ch] - 2'h1;
    @(posedge clock);
    pins.a[ch] <= phase[ch][1] ^ phase[ch][0];
    pins.b[ch] <= phase[ch][1];
    repeat (3) @(posedge clock);
  endtask

  // Index pulse of a given width, then quiet
  task automatic pulse(input int ch, input int len);
    @(posedge clock);
    pins.idx[ch] <= 1'b1;
    repeat (len) @(posedge clock);
    pins.idx[ch] <= 1'b0;
    repeat (8) @(posedge clock);
  endtask
  // Few steps between reads, far below 8191
endmodule

/* quad_pwm_servo_io.sv */
/*
  Servo I/O core: four quadrature counters with filtered index, four PWM
  generators, shared digital I/O, watchdog, status LED and an APB slave.
  Assumes all pin inputs are synchronous to clock; pads resolve the levels.
*/
// Chosen here: the register addresses and the APB interface to the registers.
// Summary of operation
// - Four quadrature channels sampled every clock
// - Count every edge of A or B
// - Host reads before 8191 counts accumulate
// - Four PWM generators, up/down or pwm+dir
// - 4095 signed duty settings including zero
// - PWM period is 2047 clock cycles
// - Optional pulse-density output mode per channel
// - Eighteen outputs, eight shared with PWM pins
// - Twenty inputs, twelve shared with encoder pins
// - Watchdog timeout tristates all output pins
// - Pins tristated until host enables driving
// - Direction high for negative unless flipped
// - Index recognised on its rising edge
// - Index pulses shorter than 175 ns rejected
// - LED shows XOR of channel zero pins while driving, low otherwise
// - Style flag picks pulse/dir or up/down
// - Shared outputs XORed onto PWM pins
// - Encoder pins readable as inputs 8 to 19
// - Output flip makes PWM pin active low
// - All host traffic over the register bus
`timescale 1ns/10ps
module quad_pwm_servo_io
#(
  parameter int WDOG_CYCLES = servo_io_pkg::WDOG_CYCLES
)
(
  input  wire logic                                 clock,
  input  wire logic                                 nrst,
  input  wire logic                                 psel,
  input  wire logic                                 penable,
  input  wire logic                                 pwrite,
  input  wire logic [7:0]                           paddr,
  input  wire logic [31:0]                          pwdata,
  output logic      [31:0]                          prdata,
  output logic                                      pready,
  output logic                                      pslverr,
  input  wire servo_io_pkg::enc_pins_s              encPins,
  input  wire logic [servo_io_pkg::NUM_DED_IN-1:0]  dedicatedInput,
  output servo_io_pkg::pwm_pins_s                   pwmOut,
  output servo_io_pkg::pwm_pins_s                   pwmOe,
  output logic      [servo_io_pkg::NUM_DED_OUT-1:0] dedicatedOutput,
  output logic      [servo_io_pkg::NUM_DED_OUT-1:0] dedicatedOutputOe,
  output logic                                      led
);

  localparam logic [servo_io_pkg::WD_W-1:0] WD_LAST = servo_io_pkg::WD_W'(WDOG_CYCLES - 1);
  localparam logic [2:0] IDX_LAST = 3'(servo_io_pkg::INDEX_CYCLES - 1);

  function automatic servo_io_pkg::step_e quadStep(input logic pa, input logic pb,
                                                   input logic a, input logic b);
    if ((a ^ pa ^ b ^ pb) == 1'b0)
      return servo_io_pkg::STEP_NONE;
    else if ((a ^ pb) == 1'b1)
      return servo_io_pkg::STEP_UP;
    else
      return servo_io_pkg::STEP_DOWN;
  endfunction

  function automatic logic [servo_io_pkg::MAG_W-1:0] dutyMag(
    input logic [servo_io_pkg::DUTY_W-1:0] d);
    logic [servo_io_pkg::DUTY_W-1:0] n;
    n = -d;
    if (d == servo_io_pkg::DUTY_MOST_NEG)
      return servo_io_pkg::PWM_PERIOD;
    else if (d[servo_io_pkg::DUTY_W-1])
      return n[servo_io_pkg::MAG_W-1:0];
    else
      return d[servo_io_pkg::MAG_W-1:0];
  endfunction

  logic [1:0]                        ctrl_reg;
  logic [servo_io_pkg::NUM_CH*2-1:0] pwmMode_reg;
  logic [servo_io_pkg::NUM_DOUT-1:0] dout_reg;
  logic [servo_io_pkg::NUM_DOUT-1:0] flip_reg;
  logic [servo_io_pkg::DUTY_W-1:0]   duty_reg [servo_io_pkg::NUM_CH];
  logic [servo_io_pkg::CNT_W-1:0]    count_reg [servo_io_pkg::NUM_CH];
  logic [servo_io_pkg::NUM_CH-1:0]   arm_reg;
  logic [servo_io_pkg::NUM_CH-1:0]   seen_reg;
  logic [servo_io_pkg::NUM_DIN-1:0]  din_reg;
  logic [servo_io_pkg::NUM_CH-1:0]   prevA_reg;
  logic [servo_io_pkg::NUM_CH-1:0]   prevB_reg;
  logic [servo_io_pkg::NUM_CH-1:0]   idxSamp_reg;
  logic [servo_io_pkg::NUM_CH-1:0]   idxLvl_reg;
  logic [2:0]                        idxCnt_reg [servo_io_pkg::NUM_CH];
  logic [servo_io_pkg::MAG_W-1:0]    pwmCnt_reg;
  logic [servo_io_pkg::MAG_W-1:0]    pdmAcc_reg [servo_io_pkg::NUM_CH];
  logic [servo_io_pkg::WD_W-1:0]     wdCnt_reg;
  logic                              trip_reg;
  logic [31:0]                       rdata_reg;
  logic                              err_reg;
  logic                              driving_reg;

  logic [31:0]                       rdata_next;
  logic                              err_next;
  logic                              xfer;
  logic                              wrEn;
  logic [servo_io_pkg::NUM_CH-1:0]   idxRise;
  servo_io_pkg::step_e               step [servo_io_pkg::NUM_CH];
  logic [servo_io_pkg::MAG_W-1:0]    mag [servo_io_pkg::NUM_CH];
  logic [servo_io_pkg::NUM_CH-1:0]   pdmHit;
  logic [servo_io_pkg::NUM_CH-1:0]   pulse;
  logic [servo_io_pkg::NUM_CH-1:0]   neg;
  logic [servo_io_pkg::NUM_CH-1:0]   genFirst;
  logic [servo_io_pkg::NUM_CH-1:0]   genSecond;
  logic [servo_io_pkg::MAG_W:0]      pdmSum [servo_io_pkg::NUM_CH];

  // Bus slave; the host reaches everything through here
  assign xfer    = psel & penable;
  assign wrEn    = xfer & pwrite;
  assign pready  = psel & penable;
  assign prdata  = rdata_reg;
  assign pslverr = xfer & err_reg;

  always_comb
  begin
    rdata_next = 32'h0;
    err_next   = 1'b0;
    unique case (paddr)
      servo_io_pkg::ADDR_CTRL:      rdata_next = {30'h0, ctrl_reg};
      servo_io_pkg::ADDR_PWM_MODE:  rdata_next = {24'h0, pwmMode_reg};
      servo_io_pkg::ADDR_DOUT:      rdata_next = {14'h0, dout_reg};
      servo_io_pkg::ADDR_DOUT_FLIP: rdata_next = {14'h0, flip_reg};
      8'h10, 8'h14, 8'h18, 8'h1c:   rdata_next = {20'h0, duty_reg[paddr[3:2]]};
      8'h20, 8'h24, 8'h28, 8'h2c:   rdata_next = {16'h0, count_reg[paddr[3:2]]};
      servo_io_pkg::ADDR_DIN:       rdata_next = {12'h0, din_reg};
      servo_io_pkg::ADDR_INDEX:     rdata_next = {24'h0, seen_reg, arm_reg};
      servo_io_pkg::ADDR_STATUS:    rdata_next = {30'h0, driving_reg, trip_reg};
      default:                      err_next   = 1'b1;
    endcase
  end

  // Read data captured in the setup phase
  always_ff @(posedge clock)
    if (!nrst)
    begin
      rdata_reg <= 32'h0;
      err_reg   <= 1'b0;
    end
    else if (psel && !penable)
    begin
      rdata_reg <= rdata_next;
      err_reg   <= err_next;
    end

  // Control and output registers
  always_ff @(posedge clock)
    if (!nrst)
    begin
      ctrl_reg    <= servo_io_pkg::CTRL_RESET;
      pwmMode_reg <= 8'h0;
      dout_reg    <= 18'h0;
      flip_reg    <= 18'h0;
      for (int i = 0; i < servo_io_pkg::NUM_CH; i++)
        duty_reg[i] <= 12'h0;
    end
    else if (wrEn && !err_reg)
    begin
      unique case (paddr)
        servo_io_pkg::ADDR_CTRL:      ctrl_reg    <= pwdata[1:0];
        servo_io_pkg::ADDR_PWM_MODE:  pwmMode_reg <= pwdata[7:0];
        servo_io_pkg::ADDR_DOUT:      dout_reg    <= pwdata[17:0];
        servo_io_pkg::ADDR_DOUT_FLIP: flip_reg    <= pwdata[17:0];
        8'h10, 8'h14, 8'h18, 8'h1c:   duty_reg[paddr[3:2]] <= pwdata[11:0];
        default:                      ;
      endcase
    end

  // Watchdog: any host transfer restarts it and clears a trip
  always_ff @(posedge clock)
    if (!nrst)
    begin
      wdCnt_reg <= 18'h0;
      trip_reg  <= 1'b0;
    end
    else if (xfer)
    begin
      wdCnt_reg <= 18'h0;
      trip_reg  <= 1'b0;
    end
    else if (!ctrl_reg[servo_io_pkg::CTRL_WDOG_EN_BIT])
      wdCnt_reg <= 18'h0;
    else if (!trip_reg)
    begin
      if (wdCnt_reg == WD_LAST)
        trip_reg <= 1'b1;
      else
        wdCnt_reg <= wdCnt_reg + 18'h1;
    end

  always_ff @(posedge clock)
    if (!nrst)
      driving_reg <= 1'b0;
    else
      driving_reg <= ctrl_reg[servo_io_pkg::CTRL_DRIVE_EN_BIT] & ~trip_reg;

  // Input sampling, shared pins read back as inputs
  always_ff @(posedge clock)
    if (!nrst)
    begin
      din_reg     <= 20'h0;
      prevA_reg   <= 4'h0;
      prevB_reg   <= 4'h0;
      idxSamp_reg <= 4'h0;
    end
    else
    begin
      din_reg     <= {encPins.b, encPins.a, encPins.idx, dedicatedInput};
      prevA_reg   <= encPins.a;
      prevB_reg   <= encPins.b;
      idxSamp_reg <= encPins.idx;
    end

  // Index filter: level follows only after a stable run
  always_ff @(posedge clock)
    if (!nrst)
    begin
      idxLvl_reg <= 4'h0;
      for (int i = 0; i < servo_io_pkg::NUM_CH; i++)
        idxCnt_reg[i] <= 3'h0;
    end
    else
      for (int i = 0; i < servo_io_pkg::NUM_CH; i++)
        if (idxSamp_reg[i] == idxLvl_reg[i])
          idxCnt_reg[i] <= 3'h0;
        else if (idxCnt_reg[i] == IDX_LAST)
        begin
          idxLvl_reg[i] <= idxSamp_reg[i];
          idxCnt_reg[i] <= 3'h0;
        end
        else
          idxCnt_reg[i] <= idxCnt_reg[i] + 3'h1;

  always_comb
  begin
    for (int i = 0; i < servo_io_pkg::NUM_CH; i++)
    begin
      idxRise[i] = ~idxLvl_reg[i] & idxSamp_reg[i] & (idxCnt_reg[i] == IDX_LAST);
      step[i]    = quadStep(prevA_reg[i], prevB_reg[i], encPins.a[i], encPins.b[i]);
    end
  end

  // Counters wrap modulo 2^16; host differences stay exact
  always_ff @(posedge clock)
    if (!nrst)
      for (int i = 0; i < servo_io_pkg::NUM_CH; i++)
        count_reg[i] <= 16'h0;
    else
      for (int i = 0; i < servo_io_pkg::NUM_CH; i++)
        if (arm_reg[i] && idxRise[i])
          count_reg[i] <= 16'h0;
        else
          unique case (step[i])
            servo_io_pkg::STEP_UP:   count_reg[i] <= count_reg[i] + 16'h1;
            servo_io_pkg::STEP_DOWN: count_reg[i] <= count_reg[i] - 16'h1;
            servo_io_pkg::STEP_NONE: ;
          endcase

  // Index arm and seen flags; an index beats a clearing write
  always_ff @(posedge clock)
    if (!nrst)
    begin
      arm_reg  <= 4'h0;
      seen_reg <= 4'h0;
    end
    else
    begin
      if (wrEn && paddr == servo_io_pkg::ADDR_INDEX)
      begin
        arm_reg  <= pwdata[3:0];
        seen_reg <= (seen_reg & ~pwdata[7:4]) | idxRise;
      end
      else
      begin
        arm_reg  <= arm_reg & ~idxRise;
        seen_reg <= seen_reg | idxRise;
      end
    end

  // PWM carrier counter
  always_ff @(posedge clock)
    if (!nrst)
      pwmCnt_reg <= 11'h0;
    else if (pwmCnt_reg == servo_io_pkg::PWM_PERIOD - 11'h1)
      pwmCnt_reg <= 11'h0;
    else
      pwmCnt_reg <= pwmCnt_reg + 11'h1;

  always_comb
  begin
    for (int i = 0; i < servo_io_pkg::NUM_CH; i++)
    begin
      mag[i]       = dutyMag(duty_reg[i]);
      neg[i]       = duty_reg[i][servo_io_pkg::DUTY_W-1];
      pdmSum[i]    = {1'b0, pdmAcc_reg[i]} + {1'b0, mag[i]};
      pdmHit[i]    = pdmSum[i] >= {1'b0, servo_io_pkg::PWM_PERIOD};
      pulse[i]     = pwmMode_reg[servo_io_pkg::PWM_MODE_PDM_LSB + i] ? pdmHit[i]
                   : (pwmCnt_reg < mag[i]);
      genFirst[i]  = pwmMode_reg[i] ? pulse[i] : pulse[i] & ~neg[i];
      genSecond[i] = pwmMode_reg[i] ? neg[i] : pulse[i] & neg[i];
    end
  end

  // Pulse-density accumulators
  always_ff @(posedge clock)
    if (!nrst)
      for (int i = 0; i < servo_io_pkg::NUM_CH; i++)
        pdmAcc_reg[i] <= 11'h0;
    else
      for (int i = 0; i < servo_io_pkg::NUM_CH; i++)
        if (pdmHit[i])
          pdmAcc_reg[i] <= 11'(pdmSum[i] - {1'b0, servo_io_pkg::PWM_PERIOD});
        else
          pdmAcc_reg[i] <= pdmSum[i][servo_io_pkg::MAG_W-1:0];

  // Pin drivers with shared outputs and polarity flip
  always_ff @(posedge clock)
    if (!nrst)
    begin
      pwmOut          <= '0;
      dedicatedOutput <= 10'h0;
    end
    else
    begin
      for (int i = 0; i < servo_io_pkg::NUM_CH; i++)
      begin
        pwmOut.first[i]  <= genFirst[i] ^ dout_reg[servo_io_pkg::SHARED_DOUT_LSB + 2*i]
                          ^ flip_reg[servo_io_pkg::SHARED_DOUT_LSB + 2*i];
        pwmOut.second[i] <= genSecond[i] ^ dout_reg[servo_io_pkg::SHARED_DOUT_LSB + 2*i + 1]
                          ^ flip_reg[servo_io_pkg::SHARED_DOUT_LSB + 2*i + 1];
      end
      dedicatedOutput <= dout_reg[9:0] ^ flip_reg[9:0];
    end

  assign pwmOe.first       = {servo_io_pkg::NUM_CH{driving_reg}};
  assign pwmOe.second      = {servo_io_pkg::NUM_CH{driving_reg}};
  assign dedicatedOutputOe = {servo_io_pkg::NUM_DED_OUT{driving_reg}};
  assign led = driving_reg & (pwmOut.first[0] ^ pwmOut.second[0]);

  // Cycles since the carrier last wrapped
  logic [servo_io_pkg::MAG_W-1:0]    carrierAge_reg;

  always_ff @(posedge clock)
    if (!nrst || pwmCnt_reg == 11'h0)
      carrierAge_reg <= 11'h0;
    else
      carrierAge_reg <= carrierAge_reg + 11'h1;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence wdExpire;
    ctrl_reg[servo_io_pkg::CTRL_WDOG_EN_BIT] && !trip_reg && wdCnt_reg == WD_LAST && !xfer;
  endsequence

  sequence tripSeen;
    trip_reg ##1 !driving_reg;
  endsequence

  wdog_trip_a: assert property (wdExpire |=> tripSeen)
    else $error("watchdog did not tristate pins");
  pins_off_a: assert property (!driving_reg |-> pwmOe == '0 && dedicatedOutputOe == 10'h0)
    else $error("pins driven while disabled");
  wdog_restart_a: assert property (xfer |=> wdCnt_reg == 18'h0 && !trip_reg)
    else $error("watchdog not restarted by transfer");
  dir_pol_a: assert property (pwmMode_reg[0] && neg[0] |-> genSecond[0])
    else $error("direction wrong for negative duty");
  led_xor_a: assert property (driving_reg |-> led == (pwmOut.first[0] ^ pwmOut.second[0]))
    else $error("led not following channel zero");
  idx_filter_a: assert property ($rose(idxLvl_reg[0]) |-> $past(idxSamp_reg[0], 1)
    && $past(idxSamp_reg[0], 2) && $past(idxSamp_reg[0], 3) && $past(idxSamp_reg[0], 4)
    && $past(idxSamp_reg[0], 5))
    else $error("short index pulse accepted");
  quad_up_a: assert property (step[0] == servo_io_pkg::STEP_UP && !(arm_reg[0] && idxRise[0])
    |=> count_reg[0] == $past(count_reg[0]) + 16'h1)
    else $error("count did not increment");
  pwm_period_a: assert property (pwmCnt_reg == 11'h0 && carrierAge_reg != 11'h0
    |-> carrierAge_reg == servo_io_pkg::PWM_PERIOD - 11'h1)
    else $error("carrier period wrong");
  zero_duty_a: assert property (duty_reg[0] == 12'h0 && !pwmMode_reg[4] |-> !pulse[0])
    else $error("zero duty produced a pulse");
  dout_xor_a: assert property (dout_reg[12] && !flip_reg[12]
    |=> pwmOut.first[1] == !$past(genFirst[1]))
    else $error("shared output not XORed");

endmodule

/* servo_io_pkg.sv */
/*
  Shared constants, types and register layout of the servo I/O block.
  Assumes a single 25 MHz clock and an APB master with 32-bit data.
*/
package servo_io_pkg;

  localparam int NUM_CH      = 4;
  localparam int NUM_DOUT    = 18;
  localparam int NUM_DED_OUT = 10;
  localparam int NUM_DED_IN  = 8;
  localparam int NUM_DIN     = 20;
  localparam int DUTY_W      = 12;
  localparam int MAG_W       = 11;
  localparam int CNT_W       = 16;
  localparam int WD_W        = 18;

  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_PWM_MODE  = 8'h04;
  localparam logic [7:0] ADDR_DOUT      = 8'h08;
  localparam logic [7:0] ADDR_DOUT_FLIP = 8'h0c;
  localparam logic [7:0] ADDR_DUTY0     = 8'h10;
  localparam logic [7:0] ADDR_COUNT0    = 8'h20;
  localparam logic [7:0] ADDR_DIN       = 8'h30;
  localparam logic [7:0] ADDR_INDEX     = 8'h34;
  localparam logic [7:0] ADDR_STATUS    = 8'h38;

  localparam int CTRL_WDOG_EN_BIT  = 0;
  localparam int CTRL_DRIVE_EN_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  localparam int PWM_MODE_PDM_LSB  = 4;
  localparam int INDEX_SEEN_LSB    = 4;
  localparam int STATUS_TRIP_BIT   = 0;
  localparam int STATUS_DRIVE_BIT  = 1;
  localparam int SHARED_DOUT_LSB   = 10;

  localparam logic [MAG_W-1:0]  PWM_PERIOD = 11'h7ff;
  localparam logic [DUTY_W-1:0] DUTY_MOST_NEG = 12'h800;

  localparam int CLK_MHZ       = 25;
  localparam int CLK_PERIOD_NS = 40;
  localparam int WDOG_TIME_US  = 6500;
  localparam int WDOG_CYCLES   = WDOG_TIME_US * CLK_MHZ;
  localparam int INDEX_MIN_NS  = 175;
  localparam int INDEX_CYCLES  = (INDEX_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {STEP_NONE, STEP_UP, STEP_DOWN} step_e;

  typedef struct packed {
    logic [NUM_CH-1:0] a;
    logic [NUM_CH-1:0] b;
    logic [NUM_CH-1:0] idx;
  } enc_pins_s;

  typedef struct packed {
    logic [NUM_CH-1:0] first;
    logic [NUM_CH-1:0] second;
  } pwm_pins_s;

endpackage

/* test_quad_pwm_servo_io.sv */
/*
  Self-checking bench of the servo I/O block, driven over APB.
  Assumes zero-wait APB answers and a shortened watchdog count.
*/
`timescale 1ns/10ps
module test_quad_pwm_servo_io;
  localparam int WDOG = 64;
  localparam int PER  = 2047;
  localparam logic [11:0] DUTY [10] = '{12'h064, 12'hf9c, 12'h000, 12'hf9c, 12'h064,
                                        12'hf9c, 12'h000, 12'h7ff, 12'h800, 12'h064};
  localparam logic [31:0] MODEV [10] = '{0, 0, 0, 1, 1, 1, 0, 0, 0, 0};
  localparam logic [31:0] DOUTV [10] = '{0, 0, 0, 0, 0, 0, 32'h400, 0, 0, 0};
  localparam logic [31:0] FLIPV [10] = '{0, 0, 0, 0, 0, 32'h800, 0, 0, 0, 32'h400};
  localparam int EXPF [10] = '{100, 0, 0, 100, 100, 100, 2047, 2047, 0, 1947};
  localparam int EXPS [10] = '{0, 100, 0, 2047, 0, 0, 0, 0, 2047, 0};

  logic                    clock   = 1'b0;
  logic                    nrst    = 1'b0;
  logic                    psel    = 1'b0;
  logic                    penable = 1'b0;
  logic                    pwrite  = 1'b0;
  logic [7:0]              paddr   = 8'h00;
  logic [31:0]             pwdata  = 32'h0;
  logic [7:0]              dedIn   = 8'h00;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  logic                    led;
  logic [9:0]              dedOut;
  logic [9:0]              dedOe;
  servo_io_pkg::enc_pins_s encPins;
  servo_io_pkg::pwm_pins_s pwmOut;
  servo_io_pkg::pwm_pins_s pwmOe;
  logic [31:0]             rd;
  logic                    err;
  int                      fails = 0;
  int                      total_checks = 0;

  always #20 clock = ~clock;

  quad_pwm_servo_io #(.WDOG_CYCLES(WDOG)) i_dut
  (
    .clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .encPins(encPins), .dedicatedInput(dedIn), .pwmOut(pwmOut),
    .pwmOe(pwmOe), .dedicatedOutput(dedOut), .dedicatedOutputOe(dedOe), .led(led)
  );

  quad_encoder_model i_enc
  (
    .clock(clock),
    .pins(encPins)
  );

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // One APB transfer; read data and error taken at the pready edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
    begin
      fails++;
      give_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(rd, exp, "register read");
  endtask

  task automatic measure(input int ch, output int f, output int s, output int x, output int e);
    logic last;
    f = 0;
    s = 0;
    x = 0;
    e = 0;
    last = pwmOut.first[ch];
    repeat (PER)
    begin
      @(posedge clock);
      f += int'(pwmOut.first[ch]);
      s += int'(pwmOut.second[ch]);
      x += int'(led !== (pwmOut.first[0] ^ pwmOut.second[0]));
      e += int'(pwmOut.first[ch] && !last);
      last = pwmOut.first[ch];
    end
  endtask

  task automatic t_reset();
    check(32'(pwmOe), 32'h0, "pwm enables");
    check(32'(dedOe), 32'h0, "output enables");
    check(32'(led), 32'h0, "led");
    rdchk(servo_io_pkg::ADDR_CTRL, 32'h1);
    rdchk(servo_io_pkg::ADDR_STATUS, 32'h0);
  endtask

  task automatic t_unmapped();
    xfer(1'b0, 8'h3c, 32'h0);
    check(32'(err), 32'h1, "error flag");
    check(rd, 32'h0, "unmapped data");
    xfer(1'b1, 8'h3c, 32'hffffffff);
    rdchk(servo_io_pkg::ADDR_DOUT, 32'h0);
  endtask

  task automatic t_dout();
    xfer(1'b1, servo_io_pkg::ADDR_CTRL, 32'h2);
    xfer(1'b1, servo_io_pkg::ADDR_DOUT, 32'h155);
    xfer(1'b1, servo_io_pkg::ADDR_DOUT_FLIP, 32'h3);
    repeat (2) @(posedge clock);
    check(32'(dedOut), 32'h156, "dedicated outputs");
    check(32'(dedOe), 32'h3ff, "output enables");
    check(32'(pwmOe), 32'hff, "pwm enables");
    xfer(1'b1, servo_io_pkg::ADDR_DOUT, 32'h0);
    xfer(1'b1, servo_io_pkg::ADDR_DOUT_FLIP, 32'h0);
  endtask

  task automatic t_enc();
    repeat (5) i_enc.step(0, 1'b1);
    rdchk(servo_io_pkg::ADDR_COUNT0, 32'h5);
    repeat (3) i_enc.step(0, 1'b0);
    rdchk(servo_io_pkg::ADDR_COUNT0, 32'h2);
    repeat (2) i_enc.step(3, 1'b1);
    rdchk(servo_io_pkg::ADDR_COUNT0 + 8'h0c, 32'h2);
    repeat (3) i_enc.step(0, 1'b0);
    rdchk(servo_io_pkg::ADDR_COUNT0, 32'hffff);
  endtask

  task automatic t_din();
    dedIn <= 8'ha5;
    repeat (3) @(posedge clock);
    rdchk(servo_io_pkg::ADDR_DIN, 32'h000980a5);
  endtask

  task automatic t_index();
    xfer(1'b1, servo_io_pkg::ADDR_INDEX, 32'h1);
    i_enc.pulse(0, 4);
    rdchk(servo_io_pkg::ADDR_INDEX, 32'h1);
    rdchk(servo_io_pkg::ADDR_COUNT0, 32'hffff);
    i_enc.pulse(0, 8);
    rdchk(servo_io_pkg::ADDR_INDEX, 32'h10);
    rdchk(servo_io_pkg::ADDR_COUNT0, 32'h0);
    xfer(1'b1, servo_io_pkg::ADDR_INDEX, 32'h10);
    rdchk(servo_io_pkg::ADDR_INDEX, 32'h0);
  endtask

  task automatic t_pwm();
    int f, s, x, e, ch, c;
    for (int k = 0; k < 13; k++)
    begin
      ch = k < 10 ? 0 : k - 9;
      c = k < 10 ? k : k - 4;
      xfer(1'b1, servo_io_pkg::ADDR_PWM_MODE, MODEV[c] << ch);
      xfer(1'b1, servo_io_pkg::ADDR_DUTY0 + 8'(4 * ch), {20'h0, DUTY[c]});
      xfer(1'b1, servo_io_pkg::ADDR_DOUT, DOUTV[c] << (2 * ch));
      xfer(1'b1, servo_io_pkg::ADDR_DOUT_FLIP, FLIPV[c] << (2 * ch));
      repeat (PER) @(posedge clock);
      measure(ch, f, s, x, e);
      check(32'(f), 32'(EXPF[c]), "first pin count");
      check(32'(s), 32'(EXPS[c]), "second pin count");
      check(32'(x), 32'h0, "led cycles");
      xfer(1'b1, servo_io_pkg::ADDR_DUTY0 + 8'(4 * ch), 32'h0);
    end
  endtask

  task automatic t_pdm();
    int f, s, x, e;
    xfer(1'b1, servo_io_pkg::ADDR_PWM_MODE, 32'h10);
    xfer(1'b1, servo_io_pkg::ADDR_DOUT, 32'h0);
    xfer(1'b1, servo_io_pkg::ADDR_DOUT_FLIP, 32'h0);
    xfer(1'b1, servo_io_pkg::ADDR_DUTY0, 32'h400);
    repeat (PER) @(posedge clock);
    measure(0, f, s, x, e);
    check(32'(f), 32'd1024, "density count");
    check(32'(e > 100), 32'h1, "density edges");
  endtask

  task automatic t_wdog();
    xfer(1'b1, servo_io_pkg::ADDR_CTRL, 32'h3);
    repeat (WDOG - 8) @(posedge clock);
    check(32'(pwmOe), 32'hff, "enables before timeout");
    repeat (20) @(posedge clock);
    check(32'(pwmOe), 32'h0, "pwm enables tripped");
    check(32'(dedOe), 32'h0, "output enables tripped");
    rdchk(servo_io_pkg::ADDR_STATUS, 32'h1);
    repeat (2) @(posedge clock);
    check(32'(dedOe), 32'h3ff, "enables after access");
    xfer(1'b1, servo_io_pkg::ADDR_CTRL, 32'h0);
    repeat (2) @(posedge clock);
    check(32'(pwmOe), 32'h0, "enables after shutdown");
  endtask

  initial
  begin
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    t_reset();
    t_unmapped();
    t_dout();
    t_enc();
    t_din();
    t_index();
    t_pwm();
    t_pdm();
    t_wdog();
    give_verdict();
  end
endmodule
